/* logic/dess_pkg.sv */
`default_nettype none
package dess_pkg;
  // ==========================================================
  // register offsets
  localparam logic [6:0] OFF_CHAN_ENABLE = 7'h58;
  localparam logic [6:0] OFF_GEN_FLAGS_1 = 7'h59;
  localparam logic [6:0] OFF_GEN_ENABLE_1 = 7'h5a;
  localparam logic [6:0] OFF_GEN_FLAGS_2 = 7'h5b;
  localparam logic [6:0] OFF_GEN_ENABLE_2 = 7'h5c;
  localparam logic [6:0] OFF_SUMMARY_ONE = 7'h5d;
  localparam logic [6:0] OFF_SUMMARY_TWO = 7'h5e;
  localparam logic [6:0] OFF_SUMMARY_THREE = 7'h5f;
  localparam logic [6:0] OFF_DECIM_INT_HIGH = 7'h60;
  localparam logic [6:0] OFF_DECIM_INT_LOW = 7'h61;
  localparam logic [6:0] OFF_DECIM_FRAC_HIGH = 7'h62;
  localparam logic [6:0] OFF_DECIM_FRAC_LOW = 7'h63;
  localparam logic [6:0] OFF_RATE_UPDATE = 7'h64;
  // ==========================================================
  // values after reset
  localparam logic [7:0] RST_CHAN_ENABLE = 8'hfe;
  localparam logic [5:0] RST_GEN_ENABLE_1 = 6'h3e;
  localparam logic [5:0] RST_GEN_ENABLE_2 = 6'h3c;
  localparam logic [7:0] RST_DECIM_INT_LOW = 8'h80;
  // ==========================================================
  // field positions
  localparam int BIT_CFG_CRC = 5;
  localparam int BIT_FUSE_CRC = 4;
  localparam int BIT_RESET_SEEN = 5;
  localparam int BIT_CLK_SWITCH = 4;
  localparam int BIT_CHIP_ERROR = 5;
  localparam int BIT_INIT_DONE = 4;
  localparam int BIT_LOAD_SOURCE = 7;
  localparam int BIT_LOAD_STROBE = 0;
  localparam int MON_SEL_LSB = 2;
  localparam int TRIP_SEL_LSB = 0;
  // ==========================================================
  // scan timing and crc
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCAN_PERIOD_NS = 100000;
  localparam int SCAN_CYCLES = SCAN_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [11:0] SCAN_LAST = 12'(SCAN_CYCLES - 1);
  localparam logic [2:0] SCAN_LAST_BYTE = 3'h7;
  localparam logic [7:0] CRC_SEED = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h07;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SCAN_IDLE = 3'b001,
    SCAN_RUN = 3'b010,
    SCAN_CHECK = 3'b100
  } dess_scan_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dess_reg_req_s;
  typedef struct packed {
    logic [11:0] int_part;
    logic [15:0] frac_part;
  } dess_decim_s;
endpackage : dess_pkg
`default_nettype wire

/* logic/dess_regs.sv */
`default_nettype none
module dess_regs (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire dess_pkg::dess_reg_req_s reg_req, // access from serial port engine
  output logic [7:0] reg_rdata, // read data, one cycle after rd
  input wire logic [3:0] spi_fault_evt, // pulses: clk count, bad rd, bad wr, crc
  input wire logic fuse_crc_bad, // level from fuse checker
  input wire logic fuse_load_done, // pulse or level from fuse loader
  input wire logic [7:0][4:0] chan_fault, // live per-channel fault bits
  input wire logic [3:0][5:0] pair_sat, // live pair saturation bits
  input wire logic clk_switch_fail_pin, // asynchronous
  input wire logic areg1_fault_pin, // asynchronous
  input wire logic areg2_fault_pin, // asynchronous
  input wire logic dreg_fault_pin, // asynchronous
  input wire logic rate_converter_update_pin, // asynchronous load trigger
  output dess_pkg::dess_decim_s active_decim,
  output logic [1:0] regulator_monitor_select,
  output logic [1:0] regulator_trip_select,
  output logic [7:0] channel_check_enables,
  output logic chip_error,
  output logic init_complete
);
  import dess_pkg::*;

  // ==========================================================
  // register storage
  logic [7:0] chan_enable; // channel check enables
  logic [5:0] gen_enable_1; // general one enables
  logic [5:0] gen_enable_2; // reset detect, monitor and trip fields
  logic [5:0] gen_flags_1; // sticky general one flags
  logic [5:0] gen_flags_2; // sticky general two flags
  logic [3:0] decim_int_high; // integer bits 11:8
  logic [7:0] decim_int_low; // integer bits 7:0
  logic [7:0] decim_frac_high; // fraction bits 15:8
  logic [7:0] decim_frac_low; // fraction bits 7:0
  logic load_source; // 0 strobe, 1 pin edge
  logic load_strobe; // armed load request
  logic [4:0] chan_loc_low; // channel 4..0 locators
  logic [2:0] chan_loc_high; // channel 7..5 locators
  logic [3:0] sat_loc; // pair locators
  logic gen1_loc; // general one active
  logic gen2_loc; // general two active
  logic rst_seen; // low only in first cycle after reset

  // ==========================================================
  // pin synchronisers
  logic [4:0] pin_meta; // first stage, read only by pin_sync
  logic [4:0] pin_sync; // second stage
  logic pin_last; // previous sync'd update pin
  logic pin_rise; // update pin rising edge

  // two flops for every asynchronous pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      pin_last <= 1'b0;
    end else begin
      pin_meta <= {rate_converter_update_pin, clk_switch_fail_pin, areg1_fault_pin,
                   areg2_fault_pin, dreg_fault_pin};
      pin_sync <= pin_meta;
      pin_last <= pin_sync[4];
    end
  end
  assign pin_rise = pin_sync[4] & ~pin_last;

  // ==========================================================
  // access decode
  // true on a write to the given offset
  function automatic logic wr_hit(input dess_reg_req_s req, input logic [6:0] off);
    wr_hit = req.wr && (req.addr == off);
  endfunction : wr_hit

  // true on a read of the given offset
  function automatic logic rd_hit(input dess_reg_req_s req, input logic [6:0] off);
    rd_hit = req.rd && (req.addr == off);
  endfunction : rd_hit

  // one crc-8 step over a byte
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    crc8_step = c;
  endfunction : crc8_step

  // ==========================================================
  // writable configuration
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_enable <= RST_CHAN_ENABLE;
      gen_enable_1 <= RST_GEN_ENABLE_1;
      gen_enable_2 <= RST_GEN_ENABLE_2;
      decim_int_high <= 4'h0;
      decim_int_low <= RST_DECIM_INT_LOW;
      decim_frac_high <= 8'h00;
      decim_frac_low <= 8'h00;
      load_source <= 1'b0;
    end else begin
      if (wr_hit(reg_req, OFF_CHAN_ENABLE)) chan_enable <= reg_req.wdata;
      if (wr_hit(reg_req, OFF_GEN_ENABLE_1)) gen_enable_1 <= reg_req.wdata[5:0];
      if (wr_hit(reg_req, OFF_GEN_ENABLE_2)) gen_enable_2 <= reg_req.wdata[5:0];
      if (wr_hit(reg_req, OFF_DECIM_INT_HIGH)) decim_int_high <= reg_req.wdata[3:0];
      if (wr_hit(reg_req, OFF_DECIM_INT_LOW)) decim_int_low <= reg_req.wdata;
      if (wr_hit(reg_req, OFF_DECIM_FRAC_HIGH)) decim_frac_high <= reg_req.wdata;
      if (wr_hit(reg_req, OFF_DECIM_FRAC_LOW)) decim_frac_low <= reg_req.wdata;
      if (wr_hit(reg_req, OFF_RATE_UPDATE)) load_source <= reg_req.wdata[BIT_LOAD_SOURCE];
    end
  end

  assign channel_check_enables = chan_enable;
  assign regulator_monitor_select = gen_enable_2[MON_SEL_LSB +: 2];
  assign regulator_trip_select = gen_enable_2[TRIP_SEL_LSB +: 2];

  // ==========================================================
  // decimation load
  logic load_now; // transfer shadow into active this cycle
  logic strobe_wr; // write of one into the load bit
  dess_decim_s shadow_decim; // programmed value

  assign strobe_wr = wr_hit(reg_req, OFF_RATE_UPDATE) && reg_req.wdata[BIT_LOAD_STROBE];
  assign shadow_decim = '{int_part: {decim_int_high, decim_int_low},
                          frac_part: {decim_frac_high, decim_frac_low}};
  // strobe loads directly, or arms the pin trigger
  assign load_now = load_source ? (load_strobe && pin_rise) : strobe_wr;

  // load bit stays set while armed, drops when the load happens
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_strobe <= 1'b0;
    end else if (strobe_wr && load_source) begin
      load_strobe <= 1'b1;
    end else if (load_now) begin
      load_strobe <= 1'b0;
    end
  end

  // active ratio moves only on a load
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_decim <= '{int_part: {4'h0, RST_DECIM_INT_LOW}, frac_part: 16'h0000};
    end else if (load_now) begin
      active_decim <= shadow_decim;
    end
  end

  // ==========================================================
  // periodic configuration crc scan
  dess_scan_e scan_state; // scan phase
  logic [11:0] scan_timer; // idle cycles counted since the last scan began
  logic [2:0] scan_idx; // byte being folded in
  logic [7:0] crc_acc; // running crc
  logic [7:0] crc_golden; // crc of last written image
  logic golden_valid; // golden holds a value
  logic cfg_dirty; // contents changed by a write since golden
  logic [7:0] cfg_img [8]; // bytes covered by the scan
  logic cfg_wr; // write to any offset from 0x58 to 0x64
  logic cfg_mismatch; // pulse: scan result differs

  assign cfg_img[0] = chan_enable;
  assign cfg_img[1] = {2'b00, gen_enable_1};
  assign cfg_img[2] = {2'b00, gen_enable_2};
  assign cfg_img[3] = {4'h0, decim_int_high};
  assign cfg_img[4] = decim_int_low;
  assign cfg_img[5] = decim_frac_high;
  assign cfg_img[6] = decim_frac_low;
  assign cfg_img[7] = {load_source, 7'h00};
  assign cfg_wr = reg_req.wr && (reg_req.addr >= OFF_CHAN_ENABLE)
                  && (reg_req.addr <= OFF_RATE_UPDATE);
  assign cfg_mismatch = (scan_state == SCAN_CHECK) && golden_valid && !cfg_dirty
                        && (crc_acc != crc_golden);

  // scan sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_state <= SCAN_IDLE;
      scan_timer <= 12'h000;
      scan_idx <= 3'h0;
      crc_acc <= CRC_SEED;
    end else begin
      case (scan_state)
        SCAN_IDLE: begin
          scan_timer <= scan_timer + 12'h001;
          if (scan_timer == SCAN_LAST) begin
            scan_timer <= 12'h000;
            scan_idx <= 3'h0;
            crc_acc <= CRC_SEED;
            scan_state <= SCAN_RUN;
          end
        end
        SCAN_RUN: begin
          crc_acc <= crc8_step(crc_acc, cfg_img[scan_idx]);
          scan_idx <= scan_idx + 3'h1;
          if (scan_idx == SCAN_LAST_BYTE) scan_state <= SCAN_CHECK;
        end
        SCAN_CHECK: begin
          scan_state <= SCAN_IDLE;
        end
        default: begin
          scan_state <= SCAN_IDLE;
        end
      endcase
    end
  end

  // golden reference, refreshed by the first scan after a write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_golden <= CRC_SEED;
      golden_valid <= 1'b0;
      cfg_dirty <= 1'b0;
    end else begin
      if (scan_state == SCAN_CHECK && (cfg_dirty || !golden_valid)) begin
        crc_golden <= crc_acc;
        golden_valid <= 1'b1;
      end
      // a write wins over the clear at check time
      if (cfg_wr) cfg_dirty <= 1'b1;
      else if (scan_state == SCAN_CHECK) cfg_dirty <= 1'b0;
    end
  end

  // ==========================================================
  // general error flags, sticky, cleared by read
  logic [5:0] gen1_evt; // raw events for general one
  logic [5:0] gen2_evt; // raw events for general two
  logic fuse_check; // fuse result sampled with each scan

  assign fuse_check = (scan_state == SCAN_CHECK) && fuse_crc_bad;
  assign gen1_evt = {cfg_mismatch, fuse_check, spi_fault_evt};
  assign gen2_evt = {!rst_seen, pin_sync[3], 1'b0,
                     pin_sync[2] & gen_enable_2[MON_SEL_LSB],
                     pin_sync[1] & gen_enable_2[MON_SEL_LSB],
                     pin_sync[0] & gen_enable_2[MON_SEL_LSB + 1]};

  // marks the first cycle after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rst_seen <= 1'b0;
    else rst_seen <= 1'b1;
  end

  // set wins over clear-on-read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_flags_1 <= 6'h00;
      gen_flags_2 <= 6'h00;
    end else begin
      gen_flags_1 <= (gen_flags_1 & {6{!rd_hit(reg_req, OFF_GEN_FLAGS_1)}})
                     | (gen1_evt & gen_enable_1);
      gen_flags_2 <= (gen_flags_2 & {6{!rd_hit(reg_req, OFF_GEN_FLAGS_2)}})
                     | (gen2_evt & {gen_enable_2[BIT_RESET_SEEN], 5'h1f});
    end
  end

  // ==========================================================
  // summary locators
  logic [5:0] sat_mask; // pair enable mask: mod, filter, clamp
  assign sat_mask = {chan_enable[5], chan_enable[6], chan_enable[7],
                     chan_enable[5], chan_enable[6], chan_enable[7]};

  // one locator per channel and per pair
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_loc_low <= 5'h00;
      chan_loc_high <= 3'h0;
      sat_loc <= 4'h0;
    end else begin
      for (int c = 0; c < 5; c++) begin
        chan_loc_low[c] <= |(chan_fault[c] & chan_enable[4:0]);
      end
      for (int c = 0; c < 3; c++) chan_loc_high[c] <= |(chan_fault[c + 5] & chan_enable[4:0]);
      for (int p = 0; p < 4; p++) sat_loc[p] <= |(pair_sat[p] & sat_mask);
    end
  end

  // general locators, chip error and init status
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gen1_loc <= 1'b0;
      gen2_loc <= 1'b0;
      chip_error <= 1'b0;
      init_complete <= 1'b0;
    end else begin
      gen1_loc <= |gen_flags_1;
      gen2_loc <= |gen_flags_2;
      chip_error <= (|gen_flags_1) || (|gen_flags_2) || (|chan_loc_low)
                    || (|chan_loc_high) || (|sat_loc);
      if (fuse_load_done) init_complete <= 1'b1;
    end
  end

  // ==========================================================
  // read data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        OFF_CHAN_ENABLE: reg_rdata <= chan_enable;
        OFF_GEN_FLAGS_1: reg_rdata <= {2'b00, gen_flags_1};
        OFF_GEN_ENABLE_1: reg_rdata <= {2'b00, gen_enable_1};
        OFF_GEN_FLAGS_2: reg_rdata <= {2'b00, gen_flags_2};
        OFF_GEN_ENABLE_2: reg_rdata <= {2'b00, gen_enable_2};
        OFF_SUMMARY_ONE: reg_rdata <= {2'b00, chip_error, chan_loc_low};
        OFF_SUMMARY_TWO: reg_rdata <= {2'b00, chip_error, gen2_loc, gen1_loc, chan_loc_high};
        OFF_SUMMARY_THREE: reg_rdata <= {2'b00, chip_error, init_complete, sat_loc};
        OFF_DECIM_INT_HIGH: reg_rdata <= {4'h0, decim_int_high};
        OFF_DECIM_INT_LOW: reg_rdata <= decim_int_low;
        OFF_DECIM_FRAC_HIGH: reg_rdata <= decim_frac_high;
        OFF_DECIM_FRAC_LOW: reg_rdata <= decim_frac_low;
        OFF_RATE_UPDATE: reg_rdata <= {load_source, 6'h00, load_strobe};
        default: reg_rdata <= 8'h00; // unmapped
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence strobe_load_s;
    strobe_wr && !load_source;
  endsequence
  sequence pin_load_s;
    load_strobe && load_source ##0 pin_rise;
  endsequence

  flag_mask_a: assert property (
    ((gen_flags_1 & ~$past(gen_flags_1)) & ~$past(gen_enable_1)) == 6'h00)
    else $error("general one flag set while disabled");
  cfg_crc_a: assert property (
    cfg_mismatch && gen_enable_1[BIT_CFG_CRC] |=> gen_flags_1[BIT_CFG_CRC])
    else $error("config crc mismatch not flagged");
  spi_flag_a: assert property (
    spi_fault_evt[3] && gen_enable_1[3] |=> gen_flags_1[3])
    else $error("clock count fault not flagged");
  chip_error_a: assert property (
    (|gen_flags_2) |=> chip_error)
    else $error("chip error missing");
  init_done_a: assert property (
    fuse_load_done |=> init_complete ##1 init_complete)
    else $error("init complete not held");
  decim_hold_a: assert property (
    cfg_wr && !load_now |=> $stable(active_decim))
    else $error("active ratio moved without load");
  strobe_load_a: assert property (
    strobe_load_s |=> active_decim == $past(shadow_decim))
    else $error("strobe did not load ratio");
  pin_load_a: assert property (
    pin_load_s |=> active_decim == $past(shadow_decim) && !load_strobe)
    else $error("pin trigger did not load ratio");
  reset_seen_a: assert property (
    !rst_seen && gen_enable_2[BIT_RESET_SEEN] |=> gen_flags_2[BIT_RESET_SEEN])
    else $error("reset detect not flagged");
  monitor_gate_a: assert property (
    $rose(gen_flags_2[0]) |-> $past(gen_enable_2[MON_SEL_LSB + 1]))
    else $error("digital supply flagged while unmonitored");
  sat_loc_a: assert property (
    (|(pair_sat[0] & sat_mask)) |=> sat_loc[0] ##1 chip_error)
    else $error("pair saturation not located");
endmodule : dess_regs
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
// ==========================================
// shared compare: counts and reports one check
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dess_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic ref_clk;
  logic rst_n;
  dess_reg_req_s reg_req;
  logic [7:0] reg_rdata;
  logic [3:0] spi_fault_evt;
  logic fuse_crc_bad;
  logic fuse_load_done;
  logic [7:0][4:0] chan_fault;
  logic [3:0][5:0] pair_sat;
  logic clk_switch_fail_pin;
  logic areg1_fault_pin;
  logic areg2_fault_pin;
  logic dreg_fault_pin;
  logic rate_converter_update_pin;
  dess_decim_s active_decim;
  logic [1:0] regulator_monitor_select;
  logic [1:0] regulator_trip_select;
  logic [7:0] channel_check_enables;
  logic chip_error;
  logic init_complete;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [7:0] d;
  // reset value table: address and expected byte
  logic [6:0] ra [8] = '{7'h58, 7'h5a, 7'h5c, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64};
  logic [7:0] rv [8] = '{8'hfe, 8'h3e, 8'h3c, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  // ==========================================
  // device under test
  dess_regs dess_regs_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .spi_fault_evt(spi_fault_evt), .fuse_crc_bad(fuse_crc_bad),
    .fuse_load_done(fuse_load_done), .chan_fault(chan_fault), .pair_sat(pair_sat),
    .clk_switch_fail_pin(clk_switch_fail_pin), .areg1_fault_pin(areg1_fault_pin),
    .areg2_fault_pin(areg2_fault_pin), .dreg_fault_pin(dreg_fault_pin),
    .rate_converter_update_pin(rate_converter_update_pin), .active_decim(active_decim),
    .regulator_monitor_select(regulator_monitor_select),
    .regulator_trip_select(regulator_trip_select),
    .channel_check_enables(channel_check_enables), .chip_error(chip_error),
    .init_complete(init_complete)
  );
  // ==========================================
  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // cut a hang short well after the fuse scan wait
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ==========================================
  // register access tasks, driven at falling edge
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge ref_clk);
    reg_req = '0;
  endtask : wr
  // read data is settled one cycle after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    reg_req = '0;
    v = reg_rdata;
  endtask : rd
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK($sformatf("reg %h", a), e, v)
  endtask : rc
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // ==========================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    spi_fault_evt = 4'h0;
    {fuse_crc_bad, fuse_load_done, rate_converter_update_pin} = 3'b000;
    chan_fault = '0;
    pair_sat = '0;
    {clk_switch_fail_pin, areg1_fault_pin, areg2_fault_pin, dreg_fault_pin} = 4'h0;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    // reset values of every writable register and of the select, enable and integer ratio outputs
    foreach (ra[i]) rc(ra[i], rv[i]);
    `CHK("monitor select", 2'h3, regulator_monitor_select)
    `CHK("trip select", 2'h0, regulator_trip_select)
    `CHK("chan enables", 8'hfe, channel_check_enables)
    `CHK("int ratio", 12'h080, active_decim.int_part)
    // reset detect: locator plus chip error, flag clears on read
    rc(7'h5e, 8'h30);
    rc(7'h5b, 8'h20);
    rc(7'h5b, 8'h00);
    // serial faults; crc check disabled after reset
    @(negedge ref_clk);
    spi_fault_evt = 4'hf;
    @(negedge ref_clk);
    spi_fault_evt = 4'h0;
    rc(7'h59, 8'h0e);
    wr(7'h5a, 8'h01);
    @(negedge ref_clk);
    spi_fault_evt = 4'hf;
    @(negedge ref_clk);
    spi_fault_evt = 4'h0;
    rc(7'h59, 8'h01);
    wr(7'h59, 8'hff);
    rc(7'h59, 8'h00);
    rc(7'h10, 8'h00);
    // supply monitor select: all, then digital only
    areg1_fault_pin = 1'b1;
    idle(5);
    rc(7'h5b, 8'h04);
    wr(7'h5c, 8'h39);
    `CHK("monitor select", 2'h2, regulator_monitor_select)
    `CHK("trip select", 2'h1, regulator_trip_select)
    rd(7'h5b, d);
    rc(7'h5b, 8'h00);
    areg1_fault_pin = 1'b0;
    dreg_fault_pin = 1'b1;
    idle(5);
    // let the synchroniser drain so the clear-on-read sticks
    dreg_fault_pin = 1'b0;
    idle(4);
    rc(7'h5b, 8'h01);
    clk_switch_fail_pin = 1'b1;
    idle(5);
    clk_switch_fail_pin = 1'b0;
    idle(4);
    rc(7'h5b, 8'h10);
    rc(7'h5b, 8'h00);
    // init done and location summaries
    fuse_load_done = 1'b1;
    chan_fault[2] = 5'h01;
    idle(3);
    rd(7'h5d, d);
    `CHK("ref detect masked", 5'h00, d[4:0])
    chan_fault[2] = 5'h02;
    chan_fault[6] = 5'h10;
    pair_sat[3] = 6'h08;
    idle(3);
    rc(7'h5d, 8'h24);
    rc(7'h5e, 8'h22);
    rc(7'h5f, 8'h38);
    `CHK("chip error", 1'b1, chip_error)
    `CHK("init done", 1'b1, init_complete)
    chan_fault = '0;
    pair_sat = '0;
    idle(4);
    `CHK("chip error", 1'b0, chip_error)
    // decimation: staged bytes stay inactive until the strobe
    wr(7'h60, 8'ha5);
    wr(7'h61, 8'h34);
    wr(7'h62, 8'h12);
    wr(7'h63, 8'h78);
    rc(7'h60, 8'h05);
    `CHK("int ratio", 12'h080, active_decim.int_part)
    `CHK("frac ratio", 16'h0000, active_decim.frac_part)
    wr(7'h64, 8'h01);
    `CHK("int ratio", 12'h534, active_decim.int_part)
    `CHK("frac ratio", 16'h1278, active_decim.frac_part)
    // pin triggered load: strobe arms, pin edge applies
    wr(7'h64, 8'h80);
    wr(7'h61, 8'h11);
    wr(7'h64, 8'h81);
    idle(3);
    `CHK("int ratio", 12'h534, active_decim.int_part)
    rate_converter_update_pin = 1'b1;
    idle(6);
    rate_converter_update_pin = 1'b0;
    `CHK("int ratio", 12'h511, active_decim.int_part)
    rc(7'h64, 8'h80);
    // fuse check result lands at the next scan, fuse enable restored first
    wr(7'h5a, 8'h3e);
    fuse_crc_bad = 1'b1;
    idle(5200);
    rc(7'h59, 8'h10);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
